// >>> apm_mux.sv
// Purpose: shared address/data pin mux, flag mode and strap decode
// Assumes: apb master on the same clock, external latch on the strobe
// Notes: one bus cycle per write to the data register with the port enabled and no cycle running
`timescale 1ns/1ns
module apm_mux import apm_pkg::*; #(
   parameter int LOCK_CYC = APM_LOCK_CYC,
   parameter int INCLK_DIV = 3
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] ad_in,
   output logic [15:0]      ad_out,
   output logic [15:0]      ad_oe,
   output logic             rd_n,
   output logic             wr_n,
   output logic             ale,
   input  wire logic [1:0]  boot_select_straps,
   input  wire logic [1:0]  clock_ratio_straps,
   output logic [3:0]       boot_mode,
   output logic [4:0]       core_ratio,
   output logic             core_run
);
   // lock counter is 13 bits and divider 5 bits, so larger values would wrap
   if (LOCK_CYC < 1 || LOCK_CYC > 8191 || INCLK_DIV < 1 || INCLK_DIV > 32) begin : g_bad_par
      $error("bad apm_mux parameters");
   end
   // ************************************************************
   // synchronisers
   // ************************************************************
   logic [15:0] ad_s;
   logic [3:0]  strap_s;
   apm_sync #(.W(16)) u_sync_ad (.clock(clock), .rst_n(rst_n), .d(ad_in), .q(ad_s));
   apm_sync #(.W(4)) u_sync_st (.clock(clock), .rst_n(rst_n),
      .d({boot_select_straps, clock_ratio_straps}), .q(strap_s));
   // ************************************************************
   // decode functions
   // ************************************************************
   function automatic logic [3:0] boot_dec(input logic [1:0] c);
      case (c)
         2'h0: boot_dec = APM_BOOT_SPI_SLV;
         2'h1: boot_dec = APM_BOOT_SPI_MST;
         2'h2: boot_dec = APM_BOOT_EPROM;
         default: boot_dec = APM_BOOT_ROM;
      endcase
   endfunction
   function automatic logic [4:0] ratio_dec(input logic [1:0] c);
      case (c)
         2'h0: ratio_dec = APM_RATIO_3;
         2'h1: ratio_dec = APM_RATIO_16;
         2'h2: ratio_dec = APM_RATIO_8;
         default: ratio_dec = APM_RATIO_RSV;
      endcase
   endfunction
   // ************************************************************
   // registers and bus
   // ************************************************************
   logic [31:0] system_control_reg_r, port_r, flag_r, power_mgmt_control_reg_r, addr_r, data_r;
   logic [3:0]  strap_r;
   logic [1:0]  cap_r;
   logic [12:0] lock_r;
   logic [4:0]  div_r;
   apm_state_t  state_r, state_nxt;
   wire acc = psel & penable;
   wire wr  = acc & pwrite;
   wire flag_mode = system_control_reg_r[APM_FLAG_BIT] & ~port_r[APM_PEN_BIT];
   wire w16 = port_r[APM_W16_BIT];
   wire busy = (state_r != APM_ST_IDLE);
   wire go  = wr & pready & (paddr == APM_DATA_OFS) & port_r[APM_PEN_BIT] & ~busy;
   wire hit = (paddr == APM_SYSTEM_CONTROL_REG_OFS) | (paddr == APM_PORT_OFS) |
              (paddr == APM_FLAG_OFS) | (paddr == APM_STRAP_OFS) |
              (paddr == APM_POWER_MGMT_CONTROL_REG_OFS) | (paddr == APM_ADDR_OFS) |
              (paddr == APM_DATA_OFS);
   wire [31:0] rd_mux =
      (paddr == APM_SYSTEM_CONTROL_REG_OFS) ? system_control_reg_r :
      (paddr == APM_PORT_OFS)   ? port_r :
      (paddr == APM_FLAG_OFS)   ? {16'h0000, ad_s[7:0], ad_s[15:8]} :
      (paddr == APM_STRAP_OFS)  ? {18'h00000, core_run, core_ratio, boot_mode, strap_r} :
      (paddr == APM_POWER_MGMT_CONTROL_REG_OFS)  ? power_mgmt_control_reg_r :
      (paddr == APM_ADDR_OFS)   ? addr_r :
      (paddr == APM_DATA_OFS)   ? data_r : 32'h0000_0000;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         system_control_reg_r <= APM_SYSTEM_CONTROL_REG_RST;
         port_r   <= APM_PORT_RST;
         flag_r   <= 32'h0000_0000;
         power_mgmt_control_reg_r  <= 32'h0000_0000;
         addr_r   <= 32'h0000_0000;
         data_r   <= 32'h0000_0000;
         prdata   <= 32'h0000_0000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         pready  <= psel & ~pready;
         pslverr <= psel & ~pready & ~hit;
         prdata  <= rd_mux;
         if (wr & pready) begin
            if (paddr == APM_SYSTEM_CONTROL_REG_OFS) system_control_reg_r <= pwdata;
            if (paddr == APM_PORT_OFS) port_r <= pwdata;
            if (paddr == APM_FLAG_OFS) flag_r <= pwdata;
            if (paddr == APM_POWER_MGMT_CONTROL_REG_OFS) power_mgmt_control_reg_r <= pwdata;
            if (paddr == APM_ADDR_OFS) addr_r <= pwdata;
            if ((paddr == APM_DATA_OFS) & ~busy) data_r <= pwdata;
         end
      end
   end
   // ************************************************************
   // straps and lock wait
   // ************************************************************
   // straps are taken from the synchronised copy a few edges after release
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cap_r   <= 2'h0;
         strap_r <= 4'h0;
         lock_r  <= 13'h0000;
         div_r   <= 5'h00;
      end else begin
         if (cap_r != 2'h3) cap_r <= cap_r + 2'h1;
         if (cap_r == 2'h2) strap_r <= strap_s;
         if (div_r == 5'(INCLK_DIV - 1)) div_r <= 5'h00;
         else div_r <= div_r + 5'h01;
         if ((div_r == 5'(INCLK_DIV - 1)) & (lock_r != 13'(LOCK_CYC)))
            lock_r <= lock_r + 13'h0001;
      end
   end
   // ************************************************************
   // pin sequencer
   // ************************************************************
   wire [15:0] addr_pins = w16 ? addr_r[15:0] : {addr_r[23:16], addr_r[15:8]};
   wire [15:0] data_pins = w16 ? data_r[15:0] : {addr_r[7:0], data_r[7:0]};
   wire [15:0] flag_pins = {flag_r[7:0], flag_r[15:8]};
   wire [15:0] flag_oe   = {flag_r[23:16], flag_r[31:24]};
   always_comb begin
      case (state_r)
         APM_ST_IDLE: state_nxt = go ? APM_ST_ADDR : APM_ST_IDLE;
         APM_ST_ADDR: state_nxt = APM_ST_DATA;
         APM_ST_DATA: state_nxt = APM_ST_IDLE;
         default:     state_nxt = APM_ST_IDLE;
      endcase
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= APM_ST_IDLE;
         ad_out     <= 16'h0000;
         ad_oe      <= 16'h0000;
         rd_n       <= 1'b1;
         wr_n       <= 1'b1;
         ale        <= 1'b0;
         boot_mode  <= 4'h0;
         core_ratio <= 5'h00;
         core_run   <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         ale        <= (state_nxt == APM_ST_ADDR);
         wr_n       <= ~(state_nxt == APM_ST_DATA);
         rd_n       <= 1'b1;
         boot_mode  <= boot_dec(strap_r[3:2]);
         core_ratio <= power_mgmt_control_reg_r[APM_OVR_BIT] ? power_mgmt_control_reg_r[4:0] : ratio_dec(strap_r[1:0]);
         core_run   <= (lock_r == 13'(LOCK_CYC));
         if (state_nxt == APM_ST_ADDR) begin
            ad_out <= addr_pins;
            ad_oe  <= 16'hffff;
         end else if (state_nxt == APM_ST_DATA) begin
            ad_out <= data_pins;
            ad_oe  <= 16'hffff;
         end else if (flag_mode) begin
            ad_out <= flag_pins;
            ad_oe  <= flag_oe;
         end else begin
            ad_out <= 16'h0000;
            ad_oe  <= 16'h0000;
         end
      end
   end
   // ************************************************************
   // checks
   // ************************************************************
   property p_flag;
      @(posedge clock) disable iff (!rst_n)
      (flag_mode & ~busy & (state_nxt == APM_ST_IDLE)) |=> (ad_out == $past(flag_pins));
   endproperty
   a_flag: assert property (p_flag) else $error("flag mapping wrong");
   property p_addr;
      @(posedge clock) disable iff (!rst_n)
      go |=> ale && (ad_out == $past(addr_pins)) && (ad_oe == 16'hffff);
   endproperty
   a_addr: assert property (p_addr) else $error("address phase wrong");
   property p_data;
      @(posedge clock) disable iff (!rst_n)
      go |=> ##1 !ale && !wr_n && (ad_out == $past(data_pins));
   endproperty
   a_data: assert property (p_data) else $error("data phase wrong");
   property p_strobe;
      @(posedge clock) disable iff (!rst_n)
      ale |-> wr_n && rd_n;
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobes overlap");
   property p_boot;
      @(posedge clock) disable iff (!rst_n)
      (cap_r == 2'h3) |=> (boot_mode == boot_dec(strap_r[3:2]));
   endproperty
   a_boot: assert property (p_boot) else $error("boot decode wrong");
   property p_ratio;
      @(posedge clock) disable iff (!rst_n)
      (cap_r == 2'h3) && !power_mgmt_control_reg_r[APM_OVR_BIT] |=> (core_ratio == ratio_dec(strap_r[1:0]));
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio decode wrong");
   property p_hold;
      @(posedge clock) disable iff (!rst_n)
      (cap_r == 2'h3) |=> $stable(strap_r);
   endproperty
   a_hold: assert property (p_hold) else $error("straps changed");
   property p_run;
      @(posedge clock) disable iff (!rst_n)
      core_run |-> ($past(lock_r) == 13'(LOCK_CYC));
   endproperty
   a_run: assert property (p_run) else $error("run before lock");
endmodule // apm_mux

// >>> apm_pkg.sv
// Purpose: constants for the address/data pin mux and strap decode block
// Assumes: apb slave with 32-bit data, one clock at 125 MHz
// Notes: register offsets are byte addresses
package apm_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [11:0] APM_SYSTEM_CONTROL_REG_OFS = 12'h000;
   localparam logic [11:0] APM_PORT_OFS   = 12'h004;
   localparam logic [11:0] APM_FLAG_OFS   = 12'h008;
   localparam logic [11:0] APM_STRAP_OFS  = 12'h00c;
   localparam logic [11:0] APM_POWER_MGMT_CONTROL_REG_OFS  = 12'h010;
   localparam logic [11:0] APM_ADDR_OFS   = 12'h014;
   localparam logic [11:0] APM_DATA_OFS   = 12'h018;
   localparam int          APM_FLAG_BIT   = 20;
   localparam int          APM_PEN_BIT    = 0;
   localparam int          APM_W16_BIT    = 1;
   localparam int          APM_OVR_BIT    = 8;
   localparam int          APM_LOCK_CYC   = 4096;
   localparam logic [31:0] APM_SYSTEM_CONTROL_REG_RST = 32'h0000_0000;
   localparam logic [31:0] APM_PORT_RST   = 32'h0000_0000;
   // ************************************************************
   // strap decodes and sequencer states
   // ************************************************************
   typedef enum logic [3:0] {
      APM_BOOT_SPI_SLV = 4'h1,
      APM_BOOT_SPI_MST = 4'h2,
      APM_BOOT_EPROM   = 4'h4,
      APM_BOOT_ROM     = 4'h8
   } apm_boot_t;
   localparam logic [4:0] APM_RATIO_3  = 5'h03;
   localparam logic [4:0] APM_RATIO_16 = 5'h10;
   localparam logic [4:0] APM_RATIO_8  = 5'h08;
   localparam logic [4:0] APM_RATIO_RSV = 5'h00;
   typedef enum logic [2:0] {
      APM_ST_IDLE = 3'h1,
      APM_ST_ADDR = 3'h2,
      APM_ST_DATA = 3'h4
   } apm_state_t;
endpackage

// >>> apm_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: asynchronous inputs, one destination clock
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
module apm_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // apm_sync

// >>> apm_ext_mem.sv
// Purpose: external address latch and write-only memory on the shared pins
// Assumes: every pin has a pull-up, so a released pin reads high
// Notes: no read path; the block only sequences writes
`timescale 1ns/1ns
module apm_ext_mem (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [15:0] ad_out,
   input  wire logic [15:0] ad_oe,
   input  wire logic        ale,
   input  wire logic        wr_n,
   input  wire logic [15:0] ext_oe,
   input  wire logic [15:0] ext_val,
   output logic [15:0]      ad_in,
   output logic [15:0]      latch_q,
   output logic [15:0]      data_q,
   output int               wr_cnt
);
   // wire level from both drivers; nobody driving means pulled high
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         ad_in[i] = ad_oe[i] ? ad_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= 16'h0000;
         data_q  <= 16'h0000;
         wr_cnt  <= 0;
      end else begin
         if (ale) begin
            latch_q <= ad_in;
         end
         if (!wr_n) begin
            data_q <= ad_in;
            wr_cnt <= wr_cnt + 1;
         end
      end
   end
endmodule // apm_ext_mem

// >>> tb_top.sv
// Purpose: apb-driven checks of pin mux, flag mode and strap decode
// Assumes: lock count shortened to 8 ticks of 3 core clocks
// Notes: expected values are worked out here, never read back from the dut
`timescale 1ns/1ns
module tb_top import apm_pkg::*; ;
   logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic        rd_n, wr_n, ale, core_run;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] ad_in, ad_out, ad_oe, ext_oe, ext_val, latch_q, data_q;
   logic [1:0]  boot_select_straps, clock_ratio_straps;
   logic [3:0]  boot_mode;
   logic [4:0]  core_ratio;
   logic [4:0]  ratio_exp [4] = '{5'h03, 5'h10, 5'h08, 5'h00};
   int          wr_cnt, miscompares, samples_checked, n0;
   apm_mux #(.LOCK_CYC(8), .INCLK_DIV(3)) dut (.clock, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .ad_in, .ad_out, .ad_oe, .rd_n, .wr_n,
      .ale, .boot_select_straps, .clock_ratio_straps, .boot_mode, .core_ratio, .core_run);
   apm_ext_mem ext (.clock, .rst_n, .ad_out, .ad_oe, .ale, .wr_n, .ext_oe, .ext_val,
      .ad_in, .latch_q, .data_q, .wr_cnt);
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d, mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      {psel, penable, pwrite} <= {2'b10, w};
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 50) chk("pready", 0, 1);
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (10) @(posedge clock);
      chk("idle strobes", {ad_oe, rd_n, wr_n, ale}, 19'h00006);
      rst_n <= 1'b1;
   endtask
   task automatic port_wr(input logic [31:0] mode, a, d, input logic [15:0] lx, dx,
                          input int nw);
      apb(1'b1, APM_PORT_OFS, mode);
      apb(1'b1, APM_ADDR_OFS, a);
      n0 = wr_cnt;
      apb(1'b1, APM_DATA_OFS, d);
      repeat (6) @(posedge clock);
      chk("write strobes", wr_cnt - n0, nw);
      chk("latched addr", latch_q, lx);
      chk("data phase", data_q, dx);
   endtask
   // ************************************************************
   // sequence
   // ************************************************************
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      #100000;
      chk("watchdog", 0, 1);
      give_verdict();
   end
   initial begin
      {psel, penable, pwrite, rst_n, paddr, pwdata} = '0;
      {ext_oe, ext_val, boot_select_straps, clock_ratio_straps} = '0;
      {miscompares, samples_checked} = '0;
      for (int c = 0; c < 4; c++) begin
         @(posedge clock);
         boot_select_straps <= c[1:0];
         clock_ratio_straps <= c[1:0];
         do_reset();
         repeat (10) @(posedge clock);
         chk("core_run early", core_run, 0);
         repeat (40) @(posedge clock);
         chk("core_run", core_run, 1);
         chk("boot_mode", boot_mode, 32'h1 << c);
         chk("core_ratio", core_ratio, ratio_exp[c]);
         boot_select_straps <= ~c[1:0];
         clock_ratio_straps <= ~c[1:0];
         repeat (6) @(posedge clock);
         chk("straps held", {boot_mode, core_ratio}, {4'h1 << c, ratio_exp[c]});
      end
      apb(1'b1, APM_POWER_MGMT_CONTROL_REG_OFS, 32'h0000_0105);
      repeat (3) @(posedge clock);
      chk("ratio override", core_ratio, 5'h05);
      $display("straps and ratio done");
      apb(1'b1, APM_FLAG_OFS, 32'hffff_12c4);
      repeat (3) @(posedge clock);
      chk("flag bit clear", ad_oe, 16'h0000);
      apb(1'b1, APM_SYSTEM_CONTROL_REG_OFS, 32'h1 << 20);
      repeat (3) @(posedge clock);
      chk("flag drive", {ad_oe, ad_out}, 32'hffff_c412);
      apb(1'b1, APM_FLAG_OFS, 32'h00ff_0000);
      ext_oe <= 16'hffff;
      ext_val <= 16'h3c5a;
      repeat (3) @(posedge clock);
      chk("flag oe", ad_oe, 16'hff00);
      apb(1'b1, APM_FLAG_OFS, 32'h0000_0000);
      repeat (4) @(posedge clock);
      apb(1'b0, APM_FLAG_OFS, 32'h0);
      chk("flag input", rd[15:0], 16'h5a3c);
      ext_oe <= 16'h0000;
      apb(1'b1, APM_PORT_OFS, 32'h1);
      repeat (3) @(posedge clock);
      chk("port owns pins", ad_oe, 16'h0000);
      $display("flag mode done");
      port_wr(32'h1, 32'h00ab_cdef, 32'h5a, 16'habcd, 16'hef5a, 1);
      port_wr(32'h3, 32'h0000_1234, 32'hbeef, 16'h1234, 16'hbeef, 1);
      port_wr(32'h0, 32'h0000_5678, 32'h1111, 16'h1234, 16'hbeef, 0);
      chk("disabled port write", wr_cnt, 2);
      chk("read strobe", {rd_n, wr_n, ale}, 3'b110);
      $display("port writes done");
      apb(1'b0, 12'h0fc, 32'h0);
      chk("unmapped error", er, 1'b1);
      $display("bus errors done");
      give_verdict();
   end
endmodule // tb_top
